// [ccie_exec.sv]
// Execution unit for clear, call, watchdog kick and file inc/dec/invert.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Clear accumulator loads zero and sets only the zero flag.
// - Call pushes the current program counter plus one onto the stack.
// - Call loads its 8-bit literal into program counter bits 7..0.
// - Call copies status bits 6..5 to PC 10..9 and clears PC 8.
// - Call takes two cycles and leaves every status flag alone.
// - Watchdog kick resets the watchdog counter to zero.
// - Watchdog kick clears the prescaler only while it serves the watchdog.
// - Watchdog kick sets the expired and sleep flags (both active low).
// - Clear file zeroes the addressed file register and sets zero flag.
// - Invert file yields the bitwise inverse and changes only the zero flag.
// - Destination bit zero writes the accumulator, one writes the file back.
// - Decrement file subtracts one and changes only the zero flag.
// - Increment file adds one modulo 256 and changes only the zero flag.
module ccie_exec
  import ccie_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Decoded instruction from the fetch path.
  input wire logic req_valid_i,
  input wire ccie_req_s req_i,
  output logic req_ready_o,
  output logic flush_o,
  // Core state seen by the rest of the core.
  output logic [10:0] pc_o,
  output logic [7:0] acc_o,
  output logic [7:0] status_o
);

  ccie_state_s s_r;
  ccie_state_s s_nxt;
  logic fire;
  logic apb_setup;
  logic apb_wr;
  logic [7:0] opnd;
  logic [7:0] res;

  //////////////////////////////////////////////////////////////////////////

  assign fire = req_valid_i && req_ready_o;
  assign apb_setup = psel_i && !penable_i;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign req_ready_o = (s_r.st == ST_RUN);
  // The prefetched word is dropped in the second cycle of a call.
  assign flush_o = (s_r.st == ST_CALL2);
  assign pready_o = 1'b1;
  assign prdata_o = s_r.rdata;
  assign pslverr_o = s_r.err & psel_i & penable_i;
  assign pc_o = s_r.pc;
  assign acc_o = s_r.acc;
  assign status_o = s_r.status;

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_nxt = s_r;
    opnd = s_r.file[req_i.faddr];
    res = 8'h00;
    // The watchdog counts behind the prescaler when it owns it.
    if (s_r.psa) begin
      s_nxt.presc = s_r.presc + 8'h01;
      if (&s_r.presc) begin
        s_nxt.wdog = s_r.wdog + 8'h01;
      end
    end else begin
      s_nxt.wdog = s_r.wdog + 8'h01;
    end
    // Read data and error are latched in the setup phase, so the access
    // phase can always finish with no wait state.
    if (apb_setup) begin
      s_nxt.err = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      if (paddr_i[1:0] != 2'b00) begin
        s_nxt.err = 1'b1;
      end else if (paddr_i[7]) begin
        s_nxt.rdata = {24'h00_0000, s_r.file[paddr_i[6:2]]};
      end else if (paddr_i == ADDR_ACC) begin
        s_nxt.rdata = {24'h00_0000, s_r.acc};
      end else if (paddr_i == ADDR_STATUS) begin
        s_nxt.rdata = {24'h00_0000, s_r.status};
      end else if (paddr_i == ADDR_PC) begin
        s_nxt.rdata = {21'h00_0000, s_r.pc};
      end else if (paddr_i == ADDR_WDOG) begin
        s_nxt.rdata = {24'h00_0000, s_r.wdog};
      end else if (paddr_i == ADDR_PRESC) begin
        s_nxt.rdata = {24'h00_0000, s_r.presc};
      end else if (paddr_i == ADDR_OPT) begin
        s_nxt.rdata = {31'h0000_0000, s_r.psa};
      end else if (paddr_i == ADDR_TOS) begin
        s_nxt.rdata = {21'h00_0000, s_r.stack[0]};
      end else begin
        s_nxt.err = 1'b1;
      end
    end
    // Software writes land first; an instruction in the same cycle wins.
    if (apb_wr && !s_r.err) begin
      if (paddr_i[7]) begin
        s_nxt.file[paddr_i[6:2]] = pwdata_i[7:0];
      end else if (paddr_i == ADDR_ACC) begin
        s_nxt.acc = pwdata_i[7:0];
      end else if (paddr_i == ADDR_STATUS) begin
        s_nxt.status = pwdata_i[7:0];
      end else if (paddr_i == ADDR_PC) begin
        s_nxt.pc = pwdata_i[10:0];
      end else if (paddr_i == ADDR_OPT) begin
        s_nxt.psa = pwdata_i[OPT_PSA];
      end
    end
    case (s_r.st)
      ST_RUN: begin
        if (fire) begin
          s_nxt.pc = s_r.pc + 11'h001;
          case (req_i.op)
            OP_CLEAR_ACC: begin
              s_nxt.acc = 8'h00;
              s_nxt.status[STAT_Z] = 1'b1;
            end
            OP_CALL: begin
              s_nxt.stack[1] = s_r.stack[0];
              s_nxt.stack[0] = s_r.pc + 11'h001;
              s_nxt.pc[7:0] = req_i.lit;
              s_nxt.pc[10:9] = s_r.status[STAT_PA_HI:STAT_PA_LO];
              s_nxt.pc[8] = 1'b0;
              s_nxt.st = ST_CALL2;
            end
            OP_KICK_WDOG: begin
              s_nxt.wdog = 8'h00;
              if (s_r.psa) begin
                s_nxt.presc = 8'h00;
              end
              s_nxt.status[STAT_EXPIRED] = 1'b1;
              s_nxt.status[STAT_SLEEP] = 1'b1;
            end
            OP_CLEAR_FILE: begin
              s_nxt.file[req_i.faddr] = 8'h00;
              s_nxt.status[STAT_Z] = 1'b1;
            end
            OP_INVERT_FILE, OP_DEC_FILE, OP_INC_FILE: begin
              if (req_i.op == OP_INVERT_FILE) begin
                res = ~opnd;
              end else if (req_i.op == OP_DEC_FILE) begin
                res = opnd - 8'h01;
              end else begin
                res = opnd + 8'h01;
              end
              if (req_i.dest) begin
                s_nxt.file[req_i.faddr] = res;
              end else begin
                s_nxt.acc = res;
              end
              s_nxt.status[STAT_Z] = (res == 8'h00);
            end
            default: begin
            end
          endcase
        end
      end
      ST_CALL2: begin
        s_nxt.st = ST_RUN;
      end
      default: begin
        s_nxt.st = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.st <= ST_RUN;
      s_r.status <= RST_STATUS;
      s_r.pc <= RST_PC;
      s_r.psa <= RST_PSA;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  // The keep checks, apart from the accumulator check in a_dest_file, leave out a software write
  // to the same register in the same cycle, because such a write lands wherever no instruction overrides.

  sequence call_taken;
    fire && req_i.op == OP_CALL;
  endsequence

  sequence call_done;
    flush_o && !req_ready_o ##1 req_ready_o && !flush_o;
  endsequence

  a_clracc_zero: assert property (
    fire && req_i.op == OP_CLEAR_ACC && !(apb_wr && paddr_i == ADDR_STATUS)
      |=> s_r.acc == 8'h00
      && s_r.status[STAT_Z]
      && s_r.status[7:3] == $past(s_r.status[7:3])
      && s_r.status[1:0] == $past(s_r.status[1:0]))
    else $error("clear accumulator result wrong");

  a_call_push: assert property (
    call_taken |=> s_r.stack[0] == $past(s_r.pc) + 11'h001
      && s_r.stack[1] == $past(s_r.stack[0]))
    else $error("call return address wrong");

  a_call_low: assert property (
    call_taken |=> s_r.pc[7:0] == $past(req_i.lit))
    else $error("call target low byte wrong");

  a_call_page: assert property (
    call_taken |=> s_r.pc[10:9] == $past(s_r.status[6:5]) && !s_r.pc[8])
    else $error("call page bits wrong");

  a_call_two: assert property (
    call_taken |=> call_done)
    else $error("call did not take two cycles");

  a_call_flags: assert property (
    call_taken ##0 !(apb_wr && paddr_i == ADDR_STATUS)
      |=> s_r.status == $past(s_r.status))
    else $error("call changed a status flag");

  a_kick_counter: assert property (
    fire && req_i.op == OP_KICK_WDOG |=> s_r.wdog == 8'h00)
    else $error("watchdog counter not cleared");

  a_kick_presc: assert property (
    fire && req_i.op == OP_KICK_WDOG
      |=> s_r.presc == 8'h00 || !$past(s_r.psa))
    else $error("prescaler not cleared when owned");

  a_kick_keep: assert property (
    fire && req_i.op == OP_KICK_WDOG && !s_r.psa
      |=> s_r.presc == $past(s_r.presc))
    else $error("prescaler touched while owned by timer");

  a_kick_flags: assert property (
    fire && req_i.op == OP_KICK_WDOG |=> s_r.status[STAT_EXPIRED]
      && s_r.status[STAT_SLEEP])
    else $error("kick did not set expired and sleep flags");

  a_clear_file_op_zero: assert property (
    fire && req_i.op == OP_CLEAR_FILE
      |=> s_r.file[$past(req_i.faddr)] == 8'h00 && s_r.status[STAT_Z])
    else $error("clear file result wrong");

  a_invert_value: assert property (
    fire && req_i.op == OP_INVERT_FILE && !req_i.dest
      |=> s_r.acc == ~$past(opnd))
    else $error("invert result wrong");

  a_dest_file: assert property (
    fire && req_i.op == OP_INC_FILE && req_i.dest
      |=> s_r.file[$past(req_i.faddr)] == $past(opnd) + 8'h01
      && s_r.acc == $past(s_r.acc))
    else $error("file destination not honoured");

  a_dec_value: assert property (
    fire && req_i.op == OP_DEC_FILE && !req_i.dest
      |=> s_r.acc == $past(opnd) - 8'h01)
    else $error("decrement result wrong");

  a_inc_wrap: assert property (
    fire && req_i.op == OP_INC_FILE && !req_i.dest && opnd == 8'hFF
      |=> s_r.acc == 8'h00 && s_r.status[STAT_Z])
    else $error("increment did not wrap to zero");

  a_zero_flag: assert property (
    fire && req_i.op == OP_DEC_FILE && opnd != 8'h01
      |=> !s_r.status[STAT_Z])
    else $error("zero flag set for nonzero result");

  a_single_cycle: assert property (
    fire && req_i.op != OP_CALL |=> req_ready_o && !flush_o)
    else $error("single cycle operation stalled");

  a_pc_step: assert property (
    fire && req_i.op != OP_CALL |=> s_r.pc == $past(s_r.pc) + 11'h001)
    else $error("program counter did not step by one");

  a_call_hold: assert property (
    flush_o && !(apb_wr && paddr_i == ADDR_PC)
      |=> s_r.pc == $past(s_r.pc))
    else $error("program counter moved in second call cycle");

  a_flush_pulse: assert property (
    flush_o |=> !flush_o)
    else $error("flush held longer than one cycle");

  a_clear_file_op_keep: assert property (
    fire && req_i.op == OP_CLEAR_FILE && !(apb_wr && paddr_i == ADDR_ACC)
      |=> s_r.acc == $past(s_r.acc))
    else $error("clear file touched the accumulator");

  a_file_flags: assert property (
    fire && req_i.op inside {OP_INVERT_FILE, OP_DEC_FILE, OP_INC_FILE}
      && !(apb_wr && paddr_i == ADDR_STATUS)
      |=> s_r.status[7:3] == $past(s_r.status[7:3])
      && s_r.status[1:0] == $past(s_r.status[1:0]))
    else $error("file operation changed a flag other than zero");

  a_invert_file: assert property (
    fire && req_i.op == OP_INVERT_FILE && req_i.dest
      |=> s_r.file[$past(req_i.faddr)] == ~$past(opnd))
    else $error("invert did not write the file back");

  a_dec_file: assert property (
    fire && req_i.op == OP_DEC_FILE && req_i.dest
      |=> s_r.file[$past(req_i.faddr)] == $past(opnd) - 8'h01)
    else $error("decrement did not write the file back");

  a_dec_wrap: assert property (
    fire && req_i.op == OP_DEC_FILE && opnd == 8'h00
      |=> !s_r.status[STAT_Z] && ($past(req_i.dest)
        ? s_r.file[$past(req_i.faddr)] == 8'hFF : s_r.acc == 8'hFF))
    else $error("decrement did not wrap to all ones");

  a_invert_zero: assert property (
    fire && req_i.op == OP_INVERT_FILE && opnd != 8'hFF
      |=> !s_r.status[STAT_Z])
    else $error("zero flag set after nonzero inversion");

  a_inc_zero: assert property (
    fire && req_i.op == OP_INC_FILE && opnd != 8'hFF
      |=> !s_r.status[STAT_Z])
    else $error("zero flag set after nonzero increment");

endmodule : ccie_exec
`default_nettype wire

// [ccie_pkg.sv]
// Shared constants, types and register map of the execution unit.
`default_nettype none
package ccie_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 11;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned FILE_N = 32;
  localparam int unsigned STACK_D = 2;
  // APB byte addresses.
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_WDOG = 8'h0C;
  localparam logic [7:0] ADDR_PRESC = 8'h10;
  localparam logic [7:0] ADDR_OPT = 8'h14;
  localparam logic [7:0] ADDR_TOS = 8'h18;
  localparam logic [7:0] ADDR_FILE = 8'h80;
  // Status and option field positions.
  localparam int unsigned STAT_Z = 2;
  localparam int unsigned STAT_SLEEP = 3;
  localparam int unsigned STAT_EXPIRED = 4;
  localparam int unsigned STAT_PA_LO = 5;
  localparam int unsigned STAT_PA_HI = 6;
  localparam int unsigned OPT_PSA = 0;
  // Reset values.
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [10:0] RST_PC = 11'h000;
  localparam logic RST_PSA = 1'b1;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CLEAR_ACC = 4'h1,
    OP_CALL = 4'h2,
    OP_KICK_WDOG = 4'h3,
    OP_CLEAR_FILE = 4'h4,
    OP_INVERT_FILE = 4'h5,
    OP_DEC_FILE = 4'h6,
    OP_INC_FILE = 4'h7
  } ccie_op_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_CALL2 = 2'b10
  } ccie_st_e;
  typedef struct packed {
    ccie_op_e op;
    logic [4:0] faddr;
    logic dest;
    logic [7:0] lit;
  } ccie_req_s;
  typedef struct packed {
    ccie_st_e st;
    logic [7:0] acc;
    logic [7:0] status;
    logic [10:0] pc;
    logic [1:0][10:0] stack;
    logic [7:0] wdog;
    logic [7:0] presc;
    logic psa;
    logic [31:0][7:0] file;
    logic [31:0] rdata;
    logic err;
  } ccie_state_s;
endpackage : ccie_pkg
`default_nettype wire

// [ccie_exec_tb.sv]
// Self-checking bench for the execution unit, driven over APB and ops.
`timescale 1ns/10ps
`default_nettype none
module ccie_exec_tb;
  import ccie_pkg::*;
  typedef struct packed {logic [1:0] k; logic [10:0] v;} ccie_exp_s;
  logic mclk_i = 0;
  logic sys_rst_i = 1;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic rv = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  ccie_req_s rq = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rdy, flush;
  logic [10:0] pc;
  logic [7:0] acc, st;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'hBC5CB401;
  logic [7:0] m_acc = 8'h00;
  logic [7:0] m_st = RST_STATUS;
  logic [10:0] m_pc = RST_PC;
  logic [10:0] m_tos = 11'h000;
  logic [7:0] m_f [32];
  logic [7:0] bnd [8] = '{8'h33, 8'hFF, 8'h01, 8'hFF,
                          8'h00, 8'h00, 8'h00, 8'h7F};
  ccie_exp_s q[$];
  ccie_exec i_ccie_exec (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .req_valid_i(rv), .req_i(rq), .req_ready_o(rdy),
    .flush_o(flush), .pc_o(pc), .acc_o(acc), .status_o(st));
  initial forever #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic fail(input string m);
    errors++;
    $display("FAIL %0t %s", $time, m);
  endtask : fail
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // Kinds: 0 exact, 1 below, 2 at least, 3 refused.
  task automatic cmp_rd(input ccie_exp_s e);
    logic ok;
    checks_done++;
    case (e.k)
      2'd0: ok = (prdata === {21'h0, e.v}) && (pslverr === 1'b0);
      2'd1: ok = (prdata < {21'h0, e.v});
      2'd2: ok = (prdata >= {21'h0, e.v});
      default: ok = (pslverr === 1'b1);
    endcase
    if (ok !== 1'b1) fail("read data or response wrong");
  endtask : cmp_rd
  task automatic cmp_bit(input logic a, input logic e);
    checks_done++;
    if (a !== e) fail("handshake or flush level wrong");
  endtask : cmp_bit
  task automatic cmp_core();
    checks_done++;
    if ({pc, acc, st} !== {m_pc, m_acc, m_st})
      fail("core state outputs wrong");
  endtask : cmp_core
  // The request stays put until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] k, input logic [10:0] v);
    if (!w) q.push_back('{k, v});
    @(posedge mclk_i);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk_i);
    pen <= 1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [1:0] k,
                    input logic [10:0] v);
    apb(1'b0, a, 8'h00, k, v);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 2'd0, 11'h0);
  endtask : wr
  task automatic op(input ccie_op_e o, input logic [4:0] f, input logic d,
                    input logic [7:0] l);
    logic [7:0] r;
    @(posedge mclk_i);
    rv <= 1;
    rq <= '{o, f, d, l};
    do begin
      @(posedge mclk_i);
    end while (rdy !== 1'b1);
    rv <= 0;
    m_pc = m_pc + 11'h001;
    r = m_f[f];
    case (o)
      OP_CLEAR_ACC: begin m_acc = 8'h00; m_st[STAT_Z] = 1'b1; end
      OP_CALL: begin m_tos = m_pc; m_pc = {m_st[6:5], 1'b0, l}; end
      OP_KICK_WDOG: m_st[4:3] = 2'b11;
      OP_NOP: begin end
      OP_CLEAR_FILE: begin m_f[f] = 8'h00; m_st[STAT_Z] = 1'b1; end
      default: begin
        r = (o == OP_INVERT_FILE) ? ~r
          : (o == OP_DEC_FILE) ? r - 8'h01 : r + 8'h01;
        m_st[STAT_Z] = (r == 8'h00);
        if (d) m_f[f] = r;
        else m_acc = r;
      end
    endcase
    #1;
    cmp_bit(rdy, o != OP_CALL);
    cmp_bit(flush, o == OP_CALL);
    cmp_core();
  endtask : op
  task automatic chk(input logic [4:0] f);
    rd(ADDR_ACC, 2'd0, {3'h0, m_acc});
    rd(ADDR_STATUS, 2'd0, {3'h0, m_st});
    rd(ADDR_PC, 2'd0, m_pc);
    rd(ADDR_FILE + {1'b0, f, 2'b00}, 2'd0, {3'h0, m_f[f]});
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i)
    if (psel && pen && pready === 1'b1 && !pwr) cmp_rd(q.pop_front());
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] r;
    logic [4:0] f;
    for (int i = 0; i < 32; i++) m_f[i] = 8'h00;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 0;
    rd(ADDR_STATUS, 2'd0, {3'h0, RST_STATUS});
    rd(8'h40, 2'd3, 11'h0);
    wr(ADDR_ACC, 8'h5A);
    wr(ADDR_STATUS, 8'h78);
    m_acc = 8'h5A;
    m_st = 8'h78;
    op(OP_CLEAR_ACC, 5'd0, 1'b0, 8'h00);
    chk(5'd0);
    wr(ADDR_PC, 8'h40);
    m_pc = 11'h040;
    op(OP_NOP, 5'd0, 1'b0, 8'h00);
    chk(5'd0);
    rd(8'h05, 2'd3, 11'h0);
    for (int i = 0; i < 32; i++) begin
      r = xs();
      f = r[4:0];
      r = xs();
      wr(ADDR_FILE + {1'b0, f, 2'b00}, (i < 8) ? bnd[i] : r[7:0]);
      m_f[f] = (i < 8) ? bnd[i] : r[7:0];
      op(ccie_op_e'(4'(4 + i % 4)), f, (i < 8) ? (i >= 4) : r[9], r[7:0]);
      chk(f);
    end
    for (int p = 0; p < 4; p++) begin
      r = xs();
      wr(ADDR_STATUS, {1'b0, 2'(p), 5'h18});
      m_st = {1'b0, 2'(p), 5'h18};
      op(OP_CALL, 5'd0, 1'b0, r[7:0]);
      rd(ADDR_TOS, 2'd0, m_tos);
      chk(5'd0);
    end
    op(OP_KICK_WDOG, 5'd0, 1'b0, 8'h00);
    repeat (30) @(posedge mclk_i);
    wr(ADDR_OPT, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    m_st = 8'h00;
    op(OP_KICK_WDOG, 5'd0, 1'b0, 8'h00);
    rd(ADDR_WDOG, 2'd1, 11'd8);
    rd(ADDR_PRESC, 2'd2, 11'd20);
    rd(ADDR_STATUS, 2'd0, {3'h0, m_st});
    wr(ADDR_OPT, 8'h01);
    repeat (40) @(posedge mclk_i);
    op(OP_KICK_WDOG, 5'd0, 1'b0, 8'h00);
    rd(ADDR_WDOG, 2'd0, 11'd0);
    rd(ADDR_PRESC, 2'd1, 11'd8);
    repeat (2) @(posedge mclk_i);
    tally_and_finish();
  end
endmodule : ccie_exec_tb
`default_nettype wire
